// ===== src/dsw_pkg.sv
// Purpose: shared constants for the serial write port of the string converter
// Assumes: frame of 16 bits, msb first, mode field then 12-bit code
// Notes: timing figures are host obligations, kept for reference only; nothing in the project checks them
package dsw_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CODE_MSB = 11;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int CNT_W = 5;
    localparam logic [4:0] LAST_BIT_CNT = 5'h0F;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam int TAP_COUNT = 4096;
    localparam int STROBE_HIGH_MIN_NS = 33;
    localparam int SHIFT_CLK_MAX_MHZ = 30;
    localparam int SYS_CLK_MHZ = 100;
    localparam int STROBE_HIGH_MIN_CYC = (STROBE_HIGH_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {
        DSW_MODE_NORMAL,
        DSW_MODE_PD_1K,
        DSW_MODE_PD_100K,
        DSW_MODE_PD_HIZ
    } dsw_mode_e;
endpackage

// ===== src/dsw_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level from another domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module dsw_sync2 (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reset_val_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;
    logic q_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_reg <= meta_reg;
        end
    end
    // reset value applied after the flops so the async reset stays constant
    assign q_out = q_reg ^ reset_val_in;
endmodule // dsw_sync2
`default_nettype wire

// ===== src/dsw_serial_write_port.sv
// Purpose: write-only three-wire serial port feeding code register and power mode
// Assumes: shift clock and frame strobe come from the host; shift clock is the link domain
// Notes: outputs are re-timed into the system clock domain by a toggle handshake
// Operation
// [R1] only strobe, shift clock and data inputs; nothing is read back
// [R2] frame starts when host drives strobe low
// [R3] while strobe low, data sampled on each shift clock falling edge
// [R4] sixteenth falling edge captures last bit and applies code and mode
// [R5] strobe may stay low or rise after sixteenth edge; both work
// [R6] host keeps strobe high at least 33 ns between frames
// [R7] new frame only after strobe has been high
// [R8] host should idle strobe low between frames for low power; the bench host model idles it high
// [R9] host shift clock no faster than 30 MHz; the bench host model clocks it at a 30 ns period, about 33 MHz
// [R10] code is straight unsigned binary, 0 to 4095
// [R11] code selects exactly one tap of the resistor string
// [R12] two ignored bits, two mode bits, then twelve code bits
// [R13] strobe rising early clears the shift register and drops the frame
// [R14] code register resets to zero until a complete frame arrives
// [R15] mode 00 normal, 01 1k, 10 100k, 11 high impedance
// [R16] msb first, first bit lands in bit 15
`timescale 1ns/1ps
`default_nettype none
module dsw_serial_write_port (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic shift_clk_in,
    input wire logic frame_n_in,
    input wire logic data_in, // [R1]
    output logic [11:0] code_out,
    output logic [1:0] mode_out,
    output logic power_mode_bit_hi_out,
    output logic power_mode_bit_lo_out,
    output logic [4095:0] tap_sel_out,
    output logic amp_enable_out,
    output logic pull_1k_out,
    output logic pull_100k_out,
    output logic update_out
);
    // link domain: strobe high resets the frame asynchronously, which both
    // aborts short frames and arms the next one without needing an edge
    logic [14:0] shift_reg;
    logic [14:0] shift_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic done_reg;
    logic done_next;
    logic [13:0] word_reg;
    logic [13:0] word_next;
    logic toggle_reg;
    logic toggle_next;
    logic frame_rst_n;
    logic frame_active;
    logic shifting;
    logic last_edge;
    logic capture;
    logic [15:0] full_word;

    assign frame_active = ~frame_n_in; // [R2]
    assign frame_rst_n = rst_n_in & frame_active; // [R2] [R7] [R13]
    assign shifting = ~done_reg; // [R5]
    assign last_edge = (cnt_reg == dsw_pkg::LAST_BIT_CNT) && shifting; // [R4]
    assign capture = last_edge && frame_active; // [R4]
    assign full_word = {shift_reg, data_in}; // [R3] [R16]
    assign shift_next = shifting ? full_word[14:0] : shift_reg; // [R3]
    assign cnt_next = shifting ? cnt_reg + 5'h01 : cnt_reg;
    assign done_next = done_reg | last_edge; // [R5]
    assign word_next = capture ? full_word[13:0] : word_reg; // [R12]
    assign toggle_next = toggle_reg ^ capture;

    always_ff @(negedge shift_clk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            shift_reg <= 15'h0000; // [R13]
        end else begin
            shift_reg <= shift_next; // [R3]
        end
    end

    always_ff @(negedge shift_clk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_reg <= 5'h00; // [R13]
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(negedge shift_clk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            done_reg <= 1'h0;
        end else begin
            done_reg <= done_next; // [R5]
        end
    end

    // captured word survives strobe release; only the power-on reset clears it
    always_ff @(negedge shift_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_reg <= 14'h0000; // [R14]
        end else begin
            word_reg <= word_next; // [R4]
        end
    end

    always_ff @(negedge shift_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            toggle_reg <= 1'h0;
        end else begin
            toggle_reg <= toggle_next;
        end
    end

    // system domain
    logic tog_sync;
    logic tog_seen_reg;
    logic take;
    logic [11:0] word_code;
    logic [1:0] word_mode;
    logic [11:0] code_reg;
    logic [11:0] code_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic update_reg;
    logic [4095:0] tap_sel_reg;
    logic [4095:0] tap_sel_next;
    logic [2:0] drive_reg;
    logic [2:0] drive_next;

    // one switch of the string closes at a time
    function automatic logic [4095:0] tap_decode(input logic [11:0] code);
        logic [4095:0] onehot;
        onehot = '0;
        onehot[code] = 1'h1;
        return onehot;
    endfunction

    // {amplifier, 1k pull, 100k pull}; high impedance drives none of them
    function automatic logic [2:0] stage_decode(input logic [1:0] mode);
        dsw_pkg::dsw_mode_e mode_dec;
        logic [2:0] stage;
        mode_dec = dsw_pkg::dsw_mode_e'(mode);
        case (mode_dec)
            dsw_pkg::DSW_MODE_NORMAL: stage = 3'h4;
            dsw_pkg::DSW_MODE_PD_1K: stage = 3'h2;
            dsw_pkg::DSW_MODE_PD_100K: stage = 3'h1;
            dsw_pkg::DSW_MODE_PD_HIZ: stage = 3'h0;
            default: stage = 3'h0;
        endcase
        return stage;
    endfunction

    dsw_sync2 u_tog_sync (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .reset_val_in(1'h0),
        .d_in(toggle_reg),
        .q_out(tog_sync)
    );

    // word_reg changes on the same link edge as the toggle and holds until the next capture,
    // so sampling it here is safe at the 30 MHz limit
    assign take = tog_sync ^ tog_seen_reg; // [R9]
    assign word_code = word_reg[dsw_pkg::CODE_MSB:0]; // [R10]
    assign word_mode = word_reg[dsw_pkg::MODE_HI_POS:dsw_pkg::MODE_LO_POS]; // [R12]
    assign code_next = take ? word_code : code_reg; // [R4]
    assign mode_next = take ? word_mode : mode_reg; // [R4]
    assign tap_sel_next = take ? tap_decode(word_code) : tap_sel_reg; // [R11]
    assign drive_next = take ? stage_decode(word_mode) : drive_reg; // [R15]

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tog_seen_reg <= 1'h0;
        end else begin
            tog_seen_reg <= tog_sync;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            update_reg <= 1'h0;
        end else begin
            update_reg <= take; // [R4]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            code_reg <= dsw_pkg::CODE_RESET; // [R14]
        end else begin
            code_reg <= code_next; // [R10]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg <= 2'h0; // [R14]
        end else begin
            mode_reg <= mode_next; // [R12]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tap_sel_reg <= 4096'h1; // [R14]
        end else begin
            tap_sel_reg <= tap_sel_next; // [R11]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            drive_reg <= 3'h4; // [R14]
        end else begin
            drive_reg <= drive_next; // [R15]
        end
    end

    assign code_out = code_reg;
    assign mode_out = mode_reg;
    assign power_mode_bit_hi_out = mode_reg[1]; // [R15]
    assign power_mode_bit_lo_out = mode_reg[0]; // [R15]
    assign tap_sel_out = tap_sel_reg; // [R11]
    assign amp_enable_out = drive_reg[2]; // [R15]
    assign pull_1k_out = drive_reg[1]; // [R15]
    assign pull_100k_out = drive_reg[0]; // [R15]
    assign update_out = update_reg;
endmodule // dsw_serial_write_port
`default_nettype wire

// ===== testbench/dsw_host_model.sv
// Purpose: host writer
// Assumes: 30 ns shift clock
// Notes: clock idles high
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model (
    output logic sclk_out,
    output logic frame_n_out,
    output logic data_out
);
    initial {sclk_out, frame_n_out, data_out} = 3'h6;
    task send(input logic [15:0] w, input int n, input bit hold);
        frame_n_out = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            data_out = w[i];
            #15 sclk_out = 1'b0;
            #15 sclk_out = 1'b1;
        end
        data_out = ~data_out;
        #(hold ? 300 : 60) frame_n_out = 1'b1;
        #150;
    endtask
endmodule // dsw_host_model
`default_nettype wire

// ===== testbench/dsw_serial_write_port_props.sv
// Purpose: port checks
// Assumes: system clock outputs
// Notes: link seen via results
`timescale 1ns/1ps
`default_nettype none
module dsw_serial_write_port_props (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [11:0] code_out,
    input wire logic [1:0] mode_out,
    input wire logic power_mode_bit_hi_out,
    input wire logic power_mode_bit_lo_out,
    input wire logic [4095:0] tap_sel_out,
    input wire logic amp_enable_out,
    input wire logic pull_1k_out,
    input wire logic pull_100k_out,
    input wire logic update_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_tap_one_hot: assert property ($onehot(tap_sel_out) && tap_sel_out[code_out]) else $error("tap");
    a_mode_bits: assert property ({power_mode_bit_hi_out, power_mode_bit_lo_out} == mode_out) else $error("bits");
    a_amp_normal: assert property (amp_enable_out == (mode_out == 2'h0)) else $error("amp");
    a_pull_low: assert property (pull_1k_out == (mode_out == 2'h1)) else $error("1k");
    a_pull_high: assert property (pull_100k_out == (mode_out == 2'h2)) else $error("100k");
    a_hold_value: assert property (!update_out |-> $stable({mode_out, code_out})) else $error("hold");
    a_update_pulse: assert property (update_out |=> !update_out) else $error("pulse");
    a_reset_zero: assert property (!$past(rst_n_in) |-> {mode_out, code_out} == 14'h0000) else $error("rst");
    c_update: cover property (update_out);
    c_hiz: cover property (mode_out == 2'h3);
    c_full: cover property (code_out == 12'hFFF);
endmodule // dsw_serial_write_port_props
bind dsw_serial_write_port dsw_serial_write_port_props dsw_serial_write_port_props_i (.*);
`default_nettype wire

// ===== testbench/dsw_serial_write_port_bench.sv
// Purpose: bench for the serial write port
// Assumes: host model drives the link
// Notes: results taken on update pulses
`timescale 1ns/1ps
`default_nettype none
module dsw_serial_write_port_bench;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    wire logic sclk, fr_n, din;
    logic [11:0] code;
    logic [1:0] mode;
    logic upd;
    wire logic amp, p1k, p100k, pb_hi, pb_lo;
    wire logic [4095:0] tap;
    logic [13:0] exp_w;
    logic [13:0] q[$];
    int err_count = 0, cmp_count = 0, cyc = 0;
    dsw_host_model dsw_host_model_i (.sclk_out(sclk), .frame_n_out(fr_n), .data_out(din));
    dsw_serial_write_port dsw_serial_write_port_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .shift_clk_in(sclk), .frame_n_in(fr_n), .data_in(din), .code_out(code), .mode_out(mode),
        .power_mode_bit_hi_out(pb_hi), .power_mode_bit_lo_out(pb_lo), .tap_sel_out(tap), .amp_enable_out(amp),
        .pull_1k_out(p1k), .pull_100k_out(p100k), .update_out(upd));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    task chk(input string n, input logic [13:0] e, input logic [13:0] g);
        cmp_count++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // pins expected from the mode table and the one-switch string, not from the design
    task chk_pins(input logic [13:0] w);
        logic [4:0] e;
        logic tap_ok;
        e = {w[13:12] == 2'h0, w[13:12] == 2'h1, w[13:12] == 2'h2, w[13:12]};
        tap_ok = (tap === (4096'h1 << w[11:0]));
        cmp_count++;
        if ({amp, p1k, p100k, pb_hi, pb_lo} !== e || !tap_ok) begin
            err_count++;
            $display("CHECK FAILED pins exp %h got %h tap_ok %0d", e, {amp, p1k, p100k, pb_hi, pb_lo}, tap_ok);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task frame(input logic [15:0] w, input bit hold);
        q.push_back(w[13:0]);
        dsw_host_model_i.send(w, 16, hold);
    endtask
    // about 670 cycles of traffic; the ceiling leaves ample margin
    always @(negedge clk_sys_in) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            tally_and_finish;
        end else if (upd === 1'b1) begin
            exp_w = q.size() ? q.pop_front() : ~{mode, code};
            chk("word", exp_w, {mode, code});
            chk_pins(exp_w);
        end
    end
    initial begin
        void'($urandom(7));
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in) rst_n_in = 1'b1;
        chk("reset", 14'h0000, {mode, code});
        chk_pins(14'h0000);
        #13;
        for (int m = 0; m < 4; m++) frame({2'($urandom), 2'(m), 12'($urandom)}, 1'b0);
        $display("test modes done");
        frame(16'h0FFF, 1'b1);
        frame(16'hC000, 1'b0);
        $display("test bounds done");
        dsw_host_model_i.send(16'h3ABC, 10, 1'b0);
        frame(16'h1555, 1'b0);
        repeat (10) @(posedge clk_sys_in);
        chk("pending", 14'h0000, 14'(q.size()));
        $display("test abort done");
        @(negedge clk_sys_in) rst_n_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk("reset", 14'h0000, {mode, code});
        chk_pins(14'h0000);
        #13;
        frame(16'h2ABC, 1'b1);
        chk("pending", 14'h0000, 14'(q.size()));
        $display("test reset done");
        tally_and_finish;
    end
endmodule // dsw_serial_write_port_bench
`default_nettype wire
